//--- rtl/qpot_top.sv
// Two-wire slave front end and register core of a quad digital pot.
// Assumes a pulled-up data wire and mclk much faster than scl.
//
// Overview of operation
// (RQ1) Data changes only while clock low; changes with clock high are start/stop.
// (RQ2) Watch both lines; falling data with clock high is start; idle until then.
// (RQ3) Master closes each transaction with data rising while clock is high.
// (RQ4) Master starts every transfer and makes the clock; device is only a slave.
// (RQ5) After eight bits the receiver pulls data low during the ninth clock.
// (RQ6) Acknowledge matching address, the command byte, and a following data byte.
// (RQ7) Upper four address bits carry a device type code checked before answering.
// (RQ8) Lower four address bits must equal the four strap inputs to answer.
// (RQ9) Each six-bit wiper position drives exactly one of sixty-four tap switches; here reset turns every tap off until the first clock after it.
// (RQ10) Wiper written directly or loaded from a stored register; both readable.
// (RQ11) Four independent pots with their own registers share one serial port.
// (RQ12) Stop after a nonvolatile write starts a timed write; bus ignored meanwhile.
// (RQ13) Address is not acknowledged while that write runs; normal once finished.
// (RQ14) Master may poll with start plus address until acknowledge returns.
// (RQ15) Command byte: instruction high nibble, register select, then pot select.
// (RQ16) Low write-protect input blocks every nonvolatile stored register write.
// (RQ17) Increment/decrement mode: each clock pulse steps wiper per data level.
// (RQ18) Data line is only pulled low, otherwise released to the pull-up.
// (RQ19) On address mismatch stay released and ignore traffic until next start.
`timescale 1ns/10ps
module qpot_top
    import qpot_pkg::*;
#(
    parameter logic [3:0]  DEV_TYPE   = 4'hA,  // Arbitrary type code
    parameter int unsigned NVW_CYCLES = NVW_CYC,
    parameter int          BUF_DEPTH  = 2
) (
    // System
    input  wire logic            mclk,
    input  wire logic            nrst,
    // Two-wire bus
    input  wire logic            scl,
    input  wire logic            sda,
    output logic                 sda_val,
    output logic                 sda_oe,
    // Straps and protection
    input  wire logic [3:0]      address_strap_inputs,
    input  wire logic            wp_n,
    // Pot state
    output logic [NPOT*TAPS-1:0] tap_on,
    output logic [NPOT*WPW-1:0]  wiper_position_register,
    output logic                 nv_busy
);
    localparam int NVW_W = $clog2(NVW_CYCLES + 1);

    generate
        if (NVW_CYCLES < 1)
            $error("qpot_top: NVW_CYCLES must be at least 1");
    endgenerate

    function automatic logic ins_legal(input logic [3:0] ins);
        case (ins)
            I_RD_W, I_WR_W, I_RD_D, I_WR_D, I_XF_DW,
            I_XF_WD, I_GX_DW, I_GX_WD, I_INCDEC: ins_legal = 1'b1;
            default:                             ins_legal = 1'b0;
        endcase
    endfunction

    function automatic logic ins_read(input logic [3:0] ins);
        ins_read = (ins == I_RD_W) || (ins == I_RD_D);
    endfunction

    // Link domain: bit caught on the scl rising edge itself
    logic link_bit_q;
    logic link_bit_d;

    always_comb
        link_bit_d = sda;

    always_ff @(posedge scl)
        link_bit_q <= link_bit_d;

    // Pin synchronisers and agreement filter
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] s1_q, s2_q, s3_q, flt_q, prv_q;
    logic [PIN_W-1:0] flt_d;

    assign pins = {address_strap_inputs, wp_n, sda, scl};

    always_comb
        flt_d = (s2_q & s3_q) | (flt_q & (s2_q | s3_q));

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s1_q  <= PIN_RST;
            s2_q  <= PIN_RST;
            s3_q  <= PIN_RST;
            flt_q <= PIN_RST;
            prv_q <= PIN_RST;
        end
        else
        begin
            s1_q  <= pins;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
            prv_q <= flt_q;
        end
    end

    logic scl_f, sda_f, scl_p, sda_p, wp_f;
    logic rise, fall, start_ev, stop_ev;
    logic [3:0] strap_f;

    assign scl_f    = flt_q[PIN_SCL];
    assign sda_f    = flt_q[PIN_SDA];
    assign scl_p    = prv_q[PIN_SCL];
    assign sda_p    = prv_q[PIN_SDA];
    assign wp_f     = flt_q[PIN_WP];
    assign strap_f  = flt_q[PIN_A +: 4];
    assign rise     = scl_f && !scl_p;
    assign fall     = !scl_f && scl_p;
    assign start_ev = scl_f && scl_p && sda_p && !sda_f;  // RQ2 RQ1
    assign stop_ev  = scl_f && scl_p && !sda_p && sda_f;  // RQ1

    qpot_buf_if #(.W(ITEM_W)) bi ();

    qpot_fifo #(
        .W     (ITEM_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .mclk (mclk),
        .nrst (nrst),
        .b    (bi.fifo)
    );

    // Executor state
    logic [WPW-1:0]   wiper_q [NPOT];
    logic [WPW-1:0]   wiper_d [NPOT];
    logic [WPW-1:0]   store_q [NPOT][NREG];
    logic [WPW-1:0]   store_d [NPOT][NREG];
    logic [7:0]       ecmd_q, ecmd_d;
    logic [WPW-1:0]   edat_q, edat_d;
    logic             pend_q, pend_d;
    logic [NVW_W-1:0] nvt_q, nvt_d;
    logic             busy_q, busy_d;
    logic [NPOT*TAPS-1:0] tap_q, tap_d;

    // Front end state
    qpot_state_e st_q, st_d;
    logic [7:0]  sh_q, sh_d, cmd_q, cmd_d, tx_q, tx_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        oe_q, oe_d;
    logic [WPW-1:0] rd_val;
    logic [3:0]  c_ins;

    assign c_ins  = cmd_q[7:CMD_INS_LSB];
    assign rd_val = (c_ins == I_RD_W)
                  ? wiper_q[cmd_q[CMD_POT_LSB +: 2]]
                  : store_q[cmd_q[CMD_POT_LSB +: 2]][cmd_q[CMD_REG_LSB +: 2]];  // RQ10

    always_comb
    begin
        st_d        = st_q;
        sh_d        = sh_q;
        cmd_d       = cmd_q;
        tx_d        = tx_q;
        cnt_d       = cnt_q;
        oe_d        = oe_q;
        bi.in_valid = 1'b0;
        bi.in_data  = '0;
        if (start_ev)
        begin
            st_d  = S_ADDR;
            cnt_d = '0;
            oe_d  = 1'b0;
        end
        else if (stop_ev)
        begin
            // Stop is queued so the executor can launch a pending store
            st_d        = S_IDLE;
            oe_d        = 1'b0;
            bi.in_valid = 1'b1;
            bi.in_data  = {K_STOP, 8'h00};
        end
        else
        begin
            case (st_q)
                S_IDLE: ;  // RQ19 RQ2
                S_ADDR, S_CMD, S_DATA:
                begin
                    if (rise)
                    begin
                        sh_d  = {sh_q[6:0], link_bit_q};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (fall && cnt_q == BITS_BYTE)
                    begin
                        cnt_d = '0;
                        st_d  = S_IDLE;  // RQ19
                        if (st_q == S_ADDR)
                        begin
                            if (sh_q[7:ADR_TYP_LSB] == DEV_TYPE   // RQ7
                                && sh_q[3:0] == strap_f           // RQ8
                                && nvt_q == '0)                   // RQ13 RQ12
                            begin
                                oe_d = 1'b1;  // RQ6 RQ5
                                st_d = S_ACK_A;
                            end
                        end
                        else if (bi.in_ready && (st_q == S_DATA
                                 || ins_legal(sh_q[7:CMD_INS_LSB])))
                        begin
                            // Full buffer refuses the byte rather than lose it
                            bi.in_valid = 1'b1;
                            bi.in_data  = {(st_q == S_CMD) ? K_CMD : K_DATA, sh_q};
                            oe_d        = 1'b1;  // RQ6 RQ5
                            if (st_q == S_CMD)
                            begin
                                cmd_d = sh_q;  // RQ15
                                st_d  = S_ACK_C;
                            end
                            else
                                st_d = S_ACK_D;
                        end
                    end
                end
                S_ACK_A:
                    if (fall)
                    begin
                        oe_d = 1'b0;
                        st_d = S_CMD;
                    end
                S_ACK_C:
                    if (fall)
                    begin
                        oe_d  = 1'b0;
                        cnt_d = '0;
                        if (ins_read(c_ins))
                        begin
                            tx_d = {2'b00, rd_val};
                            oe_d = !tx_d[7];  // RQ18
                            st_d = S_TX;
                        end
                        else if (c_ins inside {I_WR_W, I_WR_D})
                            st_d = S_DATA;
                        else if (c_ins == I_INCDEC)
                            st_d = S_STEP;
                        else
                            st_d = S_IDLE;
                    end
                S_ACK_D:
                    if (fall)
                    begin
                        oe_d = 1'b0;
                        st_d = S_IDLE;
                    end
                S_TX:
                    if (rise)
                        cnt_d = cnt_q + 4'h1;
                    else if (fall)
                    begin
                        if (cnt_q == BITS_BYTE)
                        begin
                            oe_d = 1'b0;  // RQ5
                            st_d = S_IDLE;
                        end
                        else
                        begin
                            tx_d = {tx_q[6:0], 1'b0};
                            oe_d = !tx_q[6];  // RQ18
                        end
                    end
                S_STEP:
                    if (rise)
                    begin
                        bi.in_valid = 1'b1;  // RQ17
                        bi.in_data  = {K_STEP, 7'h00, link_bit_q};
                    end
                default: st_d = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            st_q  <= S_IDLE;
            sh_q  <= 8'h00;
            cmd_q <= 8'h00;
            tx_q  <= 8'h00;
            cnt_q <= 4'h0;
            oe_q  <= 1'b0;
        end
        else
        begin
            st_q  <= st_d;
            sh_q  <= sh_d;
            cmd_q <= cmd_d;
            tx_q  <= tx_d;
            cnt_q <= cnt_d;
            oe_q  <= oe_d;
        end
    end

    // Executor: stalls while a stored write runs
    logic             pop;
    logic [1:0]       kind;
    logic [7:0]       byt;
    logic [1:0]       e_p, e_r, b_p, b_r;
    logic [3:0]       e_ins;

    assign bi.out_ready = (nvt_q == '0);  // RQ12
    assign pop   = bi.out_valid && bi.out_ready;
    assign kind  = bi.out_data[9:8];
    assign byt   = bi.out_data[7:0];
    assign e_ins = ecmd_q[7:CMD_INS_LSB];
    assign e_r   = ecmd_q[CMD_REG_LSB +: 2];
    assign e_p   = ecmd_q[CMD_POT_LSB +: 2];
    assign b_r   = byt[CMD_REG_LSB +: 2];
    assign b_p   = byt[CMD_POT_LSB +: 2];

    always_comb
    begin
        wiper_d = wiper_q;
        store_d = store_q;
        ecmd_d  = ecmd_q;
        edat_d  = edat_q;
        pend_d  = pend_q;
        nvt_d   = (nvt_q == '0) ? nvt_q : nvt_q - 1'b1;
        if (pop)
        begin
            case (kind)
                K_CMD:
                begin
                    ecmd_d = byt;
                    pend_d = (byt[7:CMD_INS_LSB] == I_XF_WD) || (byt[7:CMD_INS_LSB] == I_GX_WD);
                    if (byt[7:CMD_INS_LSB] == I_XF_DW)
                        wiper_d[b_p] = store_q[b_p][b_r];  // RQ10 RQ11
                    else if (byt[7:CMD_INS_LSB] == I_GX_DW)
                        for (int i = 0; i < NPOT; i++)
                            wiper_d[i] = store_q[i][b_r];  // RQ10
                end
                K_DATA:
                    if (e_ins == I_WR_W)
                        wiper_d[e_p] = byt[WPW-1:0];  // RQ10
                    else if (e_ins == I_WR_D)
                    begin
                        edat_d = byt[WPW-1:0];
                        pend_d = 1'b1;
                    end
                K_STEP:
                    if (e_ins == I_INCDEC)
                    begin
                        // Ends saturate rather than wrap
                        if (byt[0] && wiper_q[e_p] != WIPER_MAX)
                            wiper_d[e_p] = wiper_q[e_p] + 1'b1;  // RQ17
                        else if (!byt[0] && wiper_q[e_p] != WIPER_RST)
                            wiper_d[e_p] = wiper_q[e_p] - 1'b1;  // RQ17
                    end
                K_STOP:
                begin
                    pend_d = 1'b0;
                    if (pend_q && wp_f)  // RQ16
                    begin
                        nvt_d = NVW_W'(NVW_CYCLES);  // RQ12
                        if (e_ins == I_WR_D)
                            store_d[e_p][e_r] = edat_q;
                        else if (e_ins == I_XF_WD)
                            store_d[e_p][e_r] = wiper_q[e_p];
                        else
                            for (int i = 0; i < NPOT; i++)
                                store_d[i][e_r] = wiper_q[i];
                    end
                end
                default: ;
            endcase
        end
        busy_d = (nvt_d != '0);
        for (int i = 0; i < NPOT; i++)
            tap_d[i*TAPS +: TAPS] = TAPS'(1) << wiper_q[i];  // RQ9
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ecmd_q <= 8'h00;
            edat_q <= STORE_RST;
            pend_q <= 1'b0;
            nvt_q  <= '0;
            busy_q <= 1'b0;
            tap_q  <= '0;
            for (int i = 0; i < NPOT; i++)
            begin
                wiper_q[i] <= WIPER_RST;
                for (int j = 0; j < NREG; j++)
                    store_q[i][j] <= STORE_RST;
            end
        end
        else
        begin
            ecmd_q  <= ecmd_d;
            edat_q  <= edat_d;
            pend_q  <= pend_d;
            nvt_q   <= nvt_d;
            busy_q  <= busy_d;
            tap_q   <= tap_d;
            wiper_q <= wiper_d;
            store_q <= store_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPOT; g++)
        begin : g_wpr
            assign wiper_position_register[g*WPW +: WPW] = wiper_q[g];
        end
    endgenerate

    // Open drain: value is always low, only the enable moves
    assign sda_val = 1'b0;  // RQ18
    assign sda_oe  = oe_q;
    assign tap_on  = tap_q;
    assign nv_busy = busy_q;
endmodule // qpot_top

//--- rtl/qpot_pkg.sv
// Shared constants and types for the quad pot two-wire slave.
// Assumes a 20 MHz system clock.
package qpot_pkg;
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned NVW_TIME_US = 5000;
    localparam int unsigned NVW_CYC     = NVW_TIME_US * (CLK_HZ / 1_000_000);

    localparam int NPOT = 4;
    localparam int NREG = 4;
    localparam int WPW  = 6;
    localparam int TAPS = 64;

    localparam logic [WPW-1:0] WIPER_RST = 6'h00;
    localparam logic [WPW-1:0] STORE_RST = 6'h00;
    localparam logic [WPW-1:0] WIPER_MAX = 6'h3F;

    // Command and address byte layout
    localparam int CMD_INS_LSB = 4;
    localparam int CMD_REG_LSB = 2;
    localparam int CMD_POT_LSB = 0;
    localparam int ADR_TYP_LSB = 4;

    localparam logic [3:0] I_RD_W   = 4'h9;
    localparam logic [3:0] I_WR_W   = 4'hA;
    localparam logic [3:0] I_RD_D   = 4'hB;
    localparam logic [3:0] I_WR_D   = 4'hC;
    localparam logic [3:0] I_XF_DW  = 4'hD;
    localparam logic [3:0] I_XF_WD  = 4'hE;
    localparam logic [3:0] I_GX_DW  = 4'h1;
    localparam logic [3:0] I_GX_WD  = 4'h8;
    localparam logic [3:0] I_INCDEC = 4'h2;

    // Pin sampling vector
    localparam int PIN_W   = 7;
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_WP  = 2;
    localparam int PIN_A   = 3;
    localparam logic [PIN_W-1:0] PIN_RST = 7'h7F;

    localparam int ITEM_W = 10;
    localparam logic [3:0] BITS_BYTE = 4'h8;

    typedef enum logic [1:0] {
        K_CMD  = 2'b00,
        K_DATA = 2'b01,
        K_STEP = 2'b10,
        K_STOP = 2'b11
    } qpot_kind_e;

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0000,
        S_ADDR  = 4'b0001,
        S_ACK_A = 4'b0010,
        S_CMD   = 4'b0011,
        S_ACK_C = 4'b0100,
        S_DATA  = 4'b0101,
        S_ACK_D = 4'b0110,
        S_TX    = 4'b0111,
        S_STEP  = 4'b1000
    } qpot_state_e;
endpackage

//--- rtl/qpot_buf_if.sv
// Valid/ready path from bus front end to executor.
// Assumes both sides run on the same system clock.
`timescale 1ns/10ps
interface qpot_buf_if #(parameter int W = 10);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport prod (output in_valid, in_data, input in_ready);
    modport cons (input out_valid, out_data, output out_ready);
endinterface

//--- rtl/qpot_fifo.sv
// Small valid/ready buffer holding bus items for the executor.
// Assumes one clock and reset for both sides.
`timescale 1ns/10ps
module qpot_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 2
) (
    // System
    input wire logic mclk,
    input wire logic nrst,
    // Buffer ports
    qpot_buf_if.fifo b
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("qpot_fifo: DEPTH must be a power of two, at least 2");
    endgenerate

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW:0]  wp_q;
    logic [AW:0]  wp_d;
    logic [AW:0]  rp_q;
    logic [AW:0]  rp_d;
    logic         full;
    logic         empty;

    // Extra pointer bit tells full from empty
    assign full        = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty       = (wp_q == rp_q);
    assign b.in_ready  = !full;
    assign b.out_valid = !empty;
    assign b.out_data  = mem_q[rp_q[AW-1:0]];

    always_comb
    begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        if (b.in_valid && !full)
        begin
            mem_d[wp_q[AW-1:0]] = b.in_data;
            wp_d                = wp_q + 1'b1;
        end
        if (b.out_ready && !empty)
            rp_d = rp_q + 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= '0;
        end
        else
        begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            mem_q <= mem_d;
        end
    end
endmodule // qpot_fifo

//--- sim/qpot_top_props.sv
// Checker on the pot slave pins.
// Bound to qpot_top; sda is the wire level.
`timescale 1ns/10ps
module qpot_top_props
    import qpot_pkg::*;
#(
    parameter int unsigned NVW_CYCLES = NVW_CYC
) (
    // System
    input wire logic                  mclk,
    input wire logic                  nrst,
    // Bus and straps
    input wire logic                  scl,
    input wire logic                  sda,
    input wire logic                  sda_val,
    input wire logic                  sda_oe,
    input wire logic [3:0]            address_strap_inputs,
    input wire logic                  wp_n,
    // Pot state
    input wire logic [NPOT*TAPS-1:0]  tap_on,
    input wire logic [NPOT*WPW-1:0]   wiper_position_register,
    input wire logic                  nv_busy
);
    logic [NPOT*TAPS-1:0] tap_d, tap_q;
    logic [31:0]          cnt_d, cnt_q;
    logic                 scl_q, sda_q, act_d, act_q;

    // Raw frame tracking; the filter only lags it
    always_comb
    begin
        for (int i = 0; i < NPOT; i++)
            tap_d[i*TAPS +: TAPS] = 64'h1 << wiper_position_register[i*WPW +: WPW];
        cnt_d = nv_busy ? cnt_q + 32'h1 : 32'h0;
        act_d = act_q;
        if (scl && scl_q && sda_q != sda)
            act_d = sda_q;
    end

    always_ff @(posedge mclk)
    begin
        tap_q <= tap_d;
        scl_q <= scl;
        sda_q <= sda;
        cnt_q <= nrst ? cnt_d : 32'h0;
        act_q <= nrst ? act_d : 1'b0;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_OPEN_DRAIN: assert property (sda_val == 1'b0)
        else $error("sda_val not low");
    AST_DRIVE_EDGE: assert property ($changed(sda_oe) |-> !scl)
        else $error("drive moved, scl high");
    AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("drive short");
    AST_ACK_END: assert property ($rose(sda_oe) |-> ##[1:300] !sda_oe)
        else $error("drive stuck");
    AST_START_GATE: assert property ($rose(sda_oe) |-> act_q)
        else $error("drive outside frame");
    AST_BUSY_NACK: assert property (nv_busy |-> !sda_oe)
        else $error("drive during store");
    AST_BUSY_LEN: assert property ($fell(nv_busy) |->
        cnt_q >= NVW_CYCLES - 1 && cnt_q <= NVW_CYCLES + 1)
        else $error("store length");
    AST_WP_BLOCK: assert property ($rose(nv_busy) |-> wp_n)
        else $error("store while protected");
    AST_TAP_ONEHOT: assert property ($past(nrst) |-> tap_on == tap_q)
        else $error("tap decode");
endmodule // qpot_top_props

bind qpot_top qpot_top_props #(.NVW_CYCLES(NVW_CYCLES)) i_props (.mclk, .nrst, .scl, .sda,
    .sda_val, .sda_oe, .address_strap_inputs, .wp_n, .tap_on, .wiper_position_register,
    .nv_busy);

//--- sim/qpot_mst.sv
// Two-wire bus master model: makes scl and pulls data low.
// Assumes a pull-up on the bench wire.
`timescale 1ns/10ps
module qpot_mst (
    // System
    input  wire logic mclk,
    // Bus
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Eight mclk a phase; sampler needs over five
    task automatic half;
        repeat (8) @(posedge mclk);
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        half();
        scl <= 1'b1;
        half();
        r = sda;
        scl <= 1'b0;
        half();
    endtask

    task automatic start;
        sda_low <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask

    task automatic stop;
        sda_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b0;
        half();
    endtask

    task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(1'b1, a);
        ack = !a;
    endtask
endmodule // qpot_mst

//--- sim/tb.sv
// Bench: pot slave under a bus master model.
// Assumes a pulled-up wire; short store time.
`timescale 1ns/10ps
module tb;
    import qpot_pkg::*;
    localparam int unsigned NVW = 600;
    logic                 mclk = 1'b0;
    logic                 nrst = 1'b0;
    logic                 wp_n = 1'b1;
    logic [3:0]           straps = 4'h0;
    logic                 sda_oe, sda_val, nv_busy, scl, sda_low;
    logic [NPOT*TAPS-1:0] tap_on;
    logic [NPOT*WPW-1:0]  wiper;
    logic [5:0]           w_m [NPOT] = '{default: 6'h00};
    logic [5:0]           d_m [NPOT][NREG] = '{default: 6'h00};
    logic [3:0]           ins [9] = '{I_RD_W, I_WR_W, I_RD_D, I_WR_D, I_XF_DW, I_XF_WD,
                                      I_GX_DW, I_GX_WD, I_INCDEC};
    int                   n_errors = 0;
    int                   total_checks = 0;
    wire logic            sda = !(sda_oe || sda_low);

    always #25 mclk = !mclk;

    qpot_top #(.NVW_CYCLES(NVW)) i_dut (.mclk, .nrst, .scl, .sda, .sda_val, .sda_oe,
        .address_strap_inputs(straps), .wp_n, .tap_on, .wiper_position_register(wiper),
        .nv_busy);
    qpot_mst i_mst (.mclk, .sda, .scl, .sda_low);

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [5:0] stepf(input logic [5:0] w, input logic up);
        return up ? (w == WIPER_MAX ? w : w + 6'h01) : (w == 6'h00 ? w : w - 6'h01);
    endfunction

    task automatic op(input logic [7:0] adr, cmd, dat, input logic ack_a);
        logic [7:0] r;
        logic       a;
        logic [1:0] rs, p;
        int         n;
        rs = cmd[3:2];
        p = cmd[1:0];
        i_mst.start();
        i_mst.xbyte(adr, r, a);
        chk("addr ack", a, ack_a);
        i_mst.xbyte(cmd, r, a);
        chk("cmd ack", a, ack_a && (cmd[7:4] inside {ins}));
        if (a === 1'b1)
        begin
            case (cmd[7:4])
                I_INCDEC:
                begin
                    for (int i = 7; i >= 0; i--)
                    begin
                        i_mst.bit_io(dat[i], r[0]);
                        w_m[p] = stepf(w_m[p], dat[i]);
                    end
                    chk("step", wiper[p*WPW +: WPW], w_m[p]);
                end
                I_RD_W, I_RD_D:
                begin
                    i_mst.xbyte(8'hFF, r, a);
                    chk("read", r, {2'b00, cmd[5] ? d_m[p][rs] : w_m[p]});
                end
                I_WR_W, I_WR_D:
                begin
                    i_mst.xbyte({2'b00, dat[5:0]}, r, a);
                    chk("data ack", a, 1'b1);
                    if (!cmd[6])
                        w_m[p] = dat[5:0];
                    else if (wp_n)
                        d_m[p][rs] = dat[5:0];
                end
                I_XF_DW: w_m[p] = d_m[p][rs];
                I_XF_WD: if (wp_n) d_m[p][rs] = w_m[p];
                default:
                    for (int k = 0; k < NPOT; k++)
                        if (!cmd[7])
                            w_m[k] = d_m[k][rs];
                        else if (wp_n)
                            d_m[k][rs] = w_m[k];
            endcase
        end
        i_mst.stop();
        repeat (4) @(posedge mclk);
        n = 0;
        if (a === 1'b1 && (cmd[7:4] inside {I_WR_D, I_XF_WD, I_GX_WD}))
        begin
            chk("busy", nv_busy, wp_n);
            do
            begin
                i_mst.start();
                i_mst.xbyte(adr, r, a);
                i_mst.stop();
                n++;
            end
            while (a !== 1'b1 && n < 9);
            chk("poll count", wp_n ? n > 1 : n == 1, 1'b1);
            chk("poll ack", a, 1'b1);
        end
        if (cmd[7:4] != I_INCDEC)
            for (int k = 0; k < NPOT; k++)
            begin
                chk("wiper", wiper[k*WPW +: WPW], w_m[k]);
                chk("tap", tap_on[k*TAPS +: TAPS], 64'h1 << w_m[k]);
            end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (90000) @(posedge mclk);
        n_errors++;
        test_done();
    end

    initial
    begin
        logic [7:0] adr;
        logic [3:0] c;
        logic [1:0] rs, ps;
        void'($urandom(30));
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        straps <= 4'($urandom);
        repeat (8) @(posedge mclk);
        adr = {4'hA, straps};
        op({4'hB, straps}, 8'hA0, 8'h00, 1'b0);
        op({4'hA, ~straps}, 8'hA0, 8'h00, 1'b0);
        op(adr, 8'h30, 8'h00, 1'b1);
        // Stop may add a step; pot is rewritten
        for (int i = 0; i < 2; i++)
        begin
            op(adr, {I_WR_W, 4'h1}, i ? 8'h01 : 8'h3D, 1'b1);
            op(adr, {I_INCDEC, 4'h1}, i ? 8'h0F : 8'hF0, 1'b1);
        end
        op(adr, {I_WR_W, 4'h1}, 8'h20, 1'b1);
        for (int i = 0; i < 27; i++)
        begin
            c = i < 8 ? ins[i] : ins[$urandom_range(7)];
            rs = (c inside {I_RD_W, I_WR_W}) ? 2'b00 : 2'($urandom);
            ps = (c inside {I_GX_DW, I_GX_WD}) ? 2'b00 : 2'($urandom);
            wp_n <= ($urandom_range(3) != 0);
            @(posedge mclk);
            op(adr, {c, rs, ps}, 8'($urandom_range(63)), 1'b1);
        end
        test_done();
    end
endmodule // tb
